// ---- rtl/sfel_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfel_core (
    input  wire logic                           ref_clk,
    input  wire logic                           sys_rst,
    input  wire logic                           clk_en,
    input  wire logic                           enter_req,
    input  wire logic                           leave_req,
    input  wire logic [sfel_pkg::STORAGE_W-1:0] storage_bytes,
    input  wire logic [sfel_pkg::LEVEL_W-1:0]   nest_level,
    input  wire logic                           opnd_base_frame,
    input  wire logic                           opnd_base_stack,
    input  wire logic                           mem_ready,
    input  wire logic [31:0]                    mem_rdata,
    output logic                                mem_req,
    output logic                                mem_we,
    output logic [31:0]                         mem_addr,
    output logic [31:0]                         mem_wdata,
    output logic [31:0]                         frame_base_reg,
    output logic [31:0]                         stack_ptr_reg,
    output logic                                busy,
    output logic                                done,
    output logic [1:0]                          opnd_seg
);
    sfel_pkg::sfel_state_t state_q, state_d;
    logic [31:0] fb_q, fb_d, sp_q, sp_d, tmp_q, tmp_d, cp_q, cp_d, rd_q, rd_d;
    logic [31:0] addr_q, addr_d, wd_q, wd_d;
    logic [sfel_pkg::STORAGE_W-1:0] stor_q, stor_d;
    logic        req_q, req_d, we_q, we_d, busy_q, busy_d, done_q, done_d;
    logic [sfel_pkg::LEVEL_W-1:0]   lvl_q, lvl_d;
    logic        cnt_load, cnt_dec, none_left;
    logic [1:0]  seg_c;
    logic [1:0]  seg_q;
    logic        xfer;

    assign xfer = req_q && mem_ready;

    sfel_copy_cnt u_cnt (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .load      (cnt_load),
        .level     (nest_level),
        .dec       (cnt_dec),
        .none_left (none_left)
    );

    sfel_seg_sel u_seg (
        .base_is_frame (opnd_base_frame),
        .base_is_stack (opnd_base_stack),
        .seg           (seg_c)
    );

    // sequencer; one memory access in flight at a time keeps ordering simple
    always_comb begin
        state_d  = state_q;
        fb_d     = fb_q;
        sp_d     = sp_q;
        tmp_d    = tmp_q;
        cp_d     = cp_q;
        rd_d     = rd_q;
        addr_d   = addr_q;
        wd_d     = wd_q;
        stor_d   = stor_q;
        lvl_d    = lvl_q;
        req_d    = req_q;
        we_d     = we_q;
        busy_d   = busy_q;
        done_d   = 1'b0;
        cnt_load = 1'b0;
        cnt_dec  = 1'b0;
        unique case (state_q)
            sfel_pkg::SFEL_IDLE: begin
                if (enter_req) begin
                    // push old base: decrement first, then write
                    stor_d   = storage_bytes;
                    lvl_d    = nest_level;
                    cnt_load = 1'b1;
                    sp_d     = sfel_pkg::sfel_dec4(sp_q);
                    addr_d   = sfel_pkg::sfel_dec4(sp_q);
                    wd_d     = fb_q;
                    tmp_d    = sfel_pkg::sfel_dec4(sp_q);
                    cp_d     = fb_q;
                    req_d    = 1'b1;
                    we_d     = 1'b1;
                    busy_d   = 1'b1;
                    state_d  = sfel_pkg::SFEL_PUSHB;
                end else if (leave_req) begin
                    // release: stack pointer takes base, then pop
                    sp_d    = fb_q;
                    addr_d  = fb_q;
                    req_d   = 1'b1;
                    we_d    = 1'b0;
                    busy_d  = 1'b1;
                    state_d = sfel_pkg::SFEL_POPRD;
                end
            end
            sfel_pkg::SFEL_PUSHB: begin
                if (xfer) begin
                    req_d = 1'b0;
                    if (lvl_q == '0) begin
                        state_d = sfel_pkg::SFEL_FINISH;
                    end else if (none_left) begin
                        state_d = sfel_pkg::SFEL_PUSHT;
                    end else begin
                        state_d = sfel_pkg::SFEL_COPYRD;
                    end
                end
            end
            sfel_pkg::SFEL_COPYRD: begin
                // read the word just below the walking base copy
                if (!req_q) begin
                    // step the copy count as the read goes out, so the write can test it
                    cnt_dec = 1'b1;
                    cp_d   = sfel_pkg::sfel_dec4(cp_q);
                    addr_d = sfel_pkg::sfel_dec4(cp_q);
                    req_d  = 1'b1;
                    we_d   = 1'b0;
                end else if (xfer) begin
                    rd_d    = mem_rdata;
                    req_d   = 1'b0;
                    state_d = sfel_pkg::SFEL_COPYWR;
                end
            end
            sfel_pkg::SFEL_COPYWR: begin
                if (!req_q) begin
                    sp_d   = sfel_pkg::sfel_dec4(sp_q);
                    addr_d = sfel_pkg::sfel_dec4(sp_q);
                    wd_d   = rd_q;
                    req_d  = 1'b1;
                    we_d   = 1'b1;
                end else if (xfer) begin
                    req_d   = 1'b0;
                    state_d = none_left ? sfel_pkg::SFEL_PUSHT : sfel_pkg::SFEL_COPYRD;
                end
            end
            sfel_pkg::SFEL_PUSHT: begin
                // last display word points at the new frame
                if (!req_q) begin
                    sp_d   = sfel_pkg::sfel_dec4(sp_q);
                    addr_d = sfel_pkg::sfel_dec4(sp_q);
                    wd_d   = tmp_q;
                    req_d  = 1'b1;
                    we_d   = 1'b1;
                end else if (xfer) begin
                    req_d   = 1'b0;
                    state_d = sfel_pkg::SFEL_FINISH;
                end
            end
            sfel_pkg::SFEL_FINISH: begin
                // base at highest display word, then reserve storage
                fb_d    = tmp_q;
                sp_d    = sp_q - {{(32-sfel_pkg::STORAGE_W){1'b0}}, stor_q};
                busy_d  = 1'b0;
                done_d  = 1'b1;
                state_d = sfel_pkg::SFEL_IDLE;
            end
            sfel_pkg::SFEL_POPRD: begin
                if (xfer) begin
                    fb_d    = mem_rdata;
                    req_d   = 1'b0;
                    state_d = sfel_pkg::SFEL_POPEND;
                end
            end
            sfel_pkg::SFEL_POPEND: begin
                sp_d    = sfel_pkg::sfel_inc4(sp_q);
                busy_d  = 1'b0;
                done_d  = 1'b1;
                state_d = sfel_pkg::SFEL_IDLE;
            end
            default: begin
                state_d = sfel_pkg::SFEL_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= sfel_pkg::SFEL_IDLE;
            fb_q    <= sfel_pkg::FRAME_BASE_RST;
            sp_q    <= sfel_pkg::STACK_PTR_RST;
            tmp_q   <= 32'h0000_0000;
            cp_q    <= 32'h0000_0000;
            rd_q    <= 32'h0000_0000;
            addr_q  <= 32'h0000_0000;
            wd_q    <= 32'h0000_0000;
            stor_q  <= '0;
            lvl_q   <= '0;
            req_q   <= 1'b0;
            we_q    <= 1'b0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
            seg_q   <= sfel_pkg::SEG_DATA;
        end else if (clk_en) begin
            state_q <= state_d;
            fb_q    <= fb_d;
            sp_q    <= sp_d;
            tmp_q   <= tmp_d;
            cp_q    <= cp_d;
            rd_q    <= rd_d;
            addr_q  <= addr_d;
            wd_q    <= wd_d;
            stor_q  <= stor_d;
            lvl_q   <= lvl_d;
            req_q   <= req_d;
            we_q    <= we_d;
            busy_q  <= busy_d;
            done_q  <= done_d;
            seg_q   <= seg_c;
        end
    end

    assign mem_req        = req_q;
    assign mem_we         = we_q;
    assign mem_addr       = addr_q;
    assign mem_wdata      = wd_q;
    assign frame_base_reg = fb_q;
    assign stack_ptr_reg  = sp_q;
    assign busy           = busy_q;
    assign done           = done_q;
    assign opnd_seg       = seg_q;

    // the first write of an entry is the old base at stack pointer minus four
    AST_FIRST_PUSH: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clk_en && state_q == sfel_pkg::SFEL_IDLE && enter_req)
        |=> (mem_we && mem_wdata == $past(fb_q) && mem_addr == $past(sp_q) - 32'h0000_0004))
        else $error("first push is not the old base");

    // finish leaves the base at the temporary and subtracts storage
    AST_FINISH: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clk_en && state_q == sfel_pkg::SFEL_FINISH)
        |=> (frame_base_reg == $past(tmp_q)
             && stack_ptr_reg == $past(sp_q) - {16'h0000, $past(stor_q)}))
        else $error("finish does not set base and stack pointer");

    // release copies the base into the stack pointer first
    AST_LEAVE_COPY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clk_en && state_q == sfel_pkg::SFEL_IDLE && !enter_req && leave_req)
        |=> (stack_ptr_reg == $past(fb_q) && mem_addr == $past(fb_q) && !mem_we))
        else $error("release did not copy base to stack pointer");

    // pop: base takes read data, stack pointer rises by four afterwards
    AST_POP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clk_en && state_q == sfel_pkg::SFEL_POPRD && xfer) ##1 clk_en
        |=> (frame_base_reg == $past(mem_rdata, 2)
             && stack_ptr_reg == $past(sp_q, 2) + 32'h0000_0004))
        else $error("pop did not restore base and step stack pointer");

    // every push writes one word below the previous stack pointer
    AST_PUSH_DEC: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clk_en && $rose(mem_req) && mem_we)
        |-> (mem_addr == stack_ptr_reg))
        else $error("push address differs from stack pointer");

    // the final display word holds the new frame pointer
    AST_PUSH_TEMP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == sfel_pkg::SFEL_PUSHT && mem_req) |-> (mem_wdata == tmp_q && mem_we))
        else $error("last display word is not the new frame pointer");

    // level zero goes straight from saving the base to finishing
    AST_LEVEL0: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clk_en && state_q == sfel_pkg::SFEL_PUSHB && xfer && lvl_q == '0)
        |=> (state_q == sfel_pkg::SFEL_FINISH))
        else $error("level zero copied pointers");

    // level one pushes the temporary right after the base
    AST_LEVEL1: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clk_en && state_q == sfel_pkg::SFEL_PUSHB && xfer && lvl_q == 5'h01)
        |=> (state_q == sfel_pkg::SFEL_PUSHT))
        else $error("level one copied earlier pointers");

    // frame-based operands select the stack segment
    AST_SEG: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clk_en && opnd_base_frame) |=> (opnd_seg == sfel_pkg::SEG_STACK))
        else $error("frame-based operand not in stack segment");
endmodule
`default_nettype wire

// ---- rtl/sfel_pkg.sv ----
package sfel_pkg;
    localparam int unsigned DWORD_BYTES  = 4;
    localparam int unsigned LEVEL_W      = 5;
    localparam int unsigned STORAGE_W    = 16;
    localparam logic [31:0] STACK_PTR_RST = 32'h0000_0000;
    localparam logic [31:0] FRAME_BASE_RST = 32'h0000_0000;
    localparam logic [1:0]  SEG_DATA     = 2'h0;
    localparam logic [1:0]  SEG_STACK    = 2'h1;

    typedef enum logic [2:0] {
        SFEL_IDLE    = 3'h0,
        SFEL_PUSHB   = 3'h1,
        SFEL_COPYRD  = 3'h3,
        SFEL_COPYWR  = 3'h2,
        SFEL_PUSHT   = 3'h6,
        SFEL_FINISH  = 3'h7,
        SFEL_POPRD   = 3'h5,
        SFEL_POPEND  = 3'h4
    } sfel_state_t;

    function automatic logic [31:0] sfel_dec4(input logic [31:0] v);
        sfel_dec4 = v - 32'(DWORD_BYTES);
    endfunction

    function automatic logic [31:0] sfel_inc4(input logic [31:0] v);
        sfel_inc4 = v + 32'(DWORD_BYTES);
    endfunction
endpackage

// ---- rtl/sfel_seg_sel.sv ----
`timescale 1ns/1ps
`default_nettype none
// picks the segment for an operand address from its base register
module sfel_seg_sel (
    input  wire logic       base_is_frame,
    input  wire logic       base_is_stack,
    output logic [1:0]      seg
);
    // frame-based operands live in the stack segment
    always_comb begin
        if (base_is_frame || base_is_stack) begin
            seg = sfel_pkg::SEG_STACK;
        end else begin
            seg = sfel_pkg::SEG_DATA;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/sfel_copy_cnt.sv ----
`timescale 1ns/1ps
`default_nettype none
// counts display pointers still to copy; level is only a count
module sfel_copy_cnt (
    input  wire logic                         ref_clk,
    input  wire logic                         sys_rst,
    input  wire logic                         clk_en,
    input  wire logic                         load,
    input  wire logic [sfel_pkg::LEVEL_W-1:0] level,
    input  wire logic                         dec,
    output logic                              none_left
);
    logic [sfel_pkg::LEVEL_W-1:0] cnt_q;
    logic [sfel_pkg::LEVEL_W-1:0] cnt_d;

    // load level minus one copies; zero level never enters copy phase
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = (level == '0) ? '0 : level - 1'b1;
        end else if (dec && cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
        end
    end

    assign none_left = (cnt_q == '0);
endmodule
`default_nettype wire

// ---- verification/sfel_stack_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// behavioural stack memory on the far side; answers after wait_cyc idle cycles
module sfel_stack_mem (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_ready,
    output logic [31:0]      mem_rdata
);
    int          wait_cyc = 0;
    int          wr_cnt = 0;
    int          cnt;
    logic [31:0] mem [logic [31:0]];

    // unwritten words read back as the inverted address
    function automatic logic [31:0] peek(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : ~a;
    endfunction

    task automatic poke(input logic [31:0] a, input logic [31:0] d);
        mem[a] = d;
    endtask

    // ready lasts one cycle; data toggles outside it so stale data never looks valid
    always @(posedge ref_clk) begin
        mem_ready <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (sys_rst) begin
            cnt       <= 0;
            mem_rdata <= 32'h0000_0000;
        end else if (mem_ready) begin
            cnt <= 0;
            if (mem_we) begin
                mem[mem_addr] = mem_wdata;
                wr_cnt++;
            end
        end else if (mem_req) begin
            if (cnt >= wait_cyc) begin
                mem_ready <= 1'b1;
                mem_rdata <= peek(mem_addr);
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                           ref_clk, sys_rst, clk_en, enter_req, leave_req;
    logic                           opnd_base_frame, opnd_base_stack, mem_ready, mem_req;
    logic                           mem_we, busy, done;
    logic [sfel_pkg::STORAGE_W-1:0] storage_bytes;
    logic [sfel_pkg::LEVEL_W-1:0]   nest_level;
    logic [31:0]                    mem_rdata, mem_addr, mem_wdata, frame_base_reg, stack_ptr_reg;
    logic [1:0]                     opnd_seg;
    int                             error_cnt = 0;
    int                             total_checks = 0;
    int                             lv [5] = '{1, 2, 3, 31, 0};
    int                             st [5] = '{4, 32'hFFFF, 0, 8, 32'h20};
    int                             wt [5] = '{0, 2, 1, 0, 3};

    sfel_core sfel_core_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .enter_req(enter_req), .leave_req(leave_req), .storage_bytes(storage_bytes),
        .nest_level(nest_level), .opnd_base_frame(opnd_base_frame),
        .opnd_base_stack(opnd_base_stack), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .frame_base_reg(frame_base_reg), .stack_ptr_reg(stack_ptr_reg), .busy(busy),
        .done(done), .opnd_seg(opnd_seg));
    sfel_stack_mem sfel_stack_mem_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ready(mem_ready), .mem_rdata(mem_rdata));

    // 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_bit(input logic exp, input logic got);
        chk_word({31'h0, exp}, {31'h0, got});
    endtask

    // bounded wait for the completion pulse, then it must drop after one cycle
    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1) begin
            @(negedge ref_clk);
            n++;
            if (n > 2000) begin
                error_cnt++;
                conclude();
            end
        end
        chk_bit(1'b0, busy);
        @(negedge ref_clk);
        chk_bit(1'b0, done);
    endtask

    // entry with a release request pushed while busy, which must be ignored
    task automatic run_enter(input int storage, input int lvl, input int waits);
        logic [31:0] sp0, fb0, tmp;
        int          w0;
        sp0 = stack_ptr_reg;
        fb0 = frame_base_reg;
        tmp = sp0 - 32'h0000_0004;
        sfel_stack_mem_inst.wait_cyc = waits;
        for (int i = 1; i < lvl; i++) sfel_stack_mem_inst.poke(fb0 - 32'(4 * i), 32'hC0DE_0000 | 32'(i));
        w0 = sfel_stack_mem_inst.wr_cnt;
        storage_bytes = storage[sfel_pkg::STORAGE_W-1:0];
        nest_level = lvl[sfel_pkg::LEVEL_W-1:0];
        enter_req = 1'b1;
        @(negedge ref_clk);
        chk_bit(1'b1, busy);
        enter_req = 1'b0;
        leave_req = 1'b1;
        @(negedge ref_clk);
        leave_req = 1'b0;
        wait_done();
        chk_word(tmp, frame_base_reg);
        chk_word(tmp - 32'(4 * lvl) - 32'(storage), stack_ptr_reg);
        chk_word(fb0, sfel_stack_mem_inst.peek(tmp));
        for (int i = 1; i < lvl; i++) chk_word(32'hC0DE_0000 | 32'(i), sfel_stack_mem_inst.peek(tmp - 32'(4 * i)));
        if (lvl > 0) chk_word(tmp, sfel_stack_mem_inst.peek(tmp - 32'(4 * lvl)));
        chk_word(32'((lvl == 0) ? 1 : lvl + 1), 32'(sfel_stack_mem_inst.wr_cnt - w0));
    endtask

    task automatic run_leave();
        logic [31:0] fb1, exp_fb;
        fb1 = frame_base_reg;
        exp_fb = sfel_stack_mem_inst.peek(fb1);
        leave_req = 1'b1;
        @(negedge ref_clk);
        leave_req = 1'b0;
        wait_done();
        chk_word(exp_fb, frame_base_reg);
        chk_word(fb1 + 32'h0000_0004, stack_ptr_reg);
    endtask

    // level one entry with the clock enable dropped while the base push is pending
    task automatic run_freeze();
        logic [31:0] sp0, a0;
        sp0 = stack_ptr_reg;
        sfel_stack_mem_inst.wait_cyc = 0;
        nest_level = 5'h01;
        storage_bytes = 16'h0010;
        enter_req = 1'b1;
        @(negedge ref_clk);
        enter_req = 1'b0;
        clk_en = 1'b0;
        a0 = mem_addr;
        repeat (4) @(negedge ref_clk);
        chk_word(a0, mem_addr);
        chk_word(sp0 - 32'h0000_0004, stack_ptr_reg);
        chk_bit(1'b1, mem_req);
        chk_bit(1'b1, busy);
        clk_en = 1'b1;
        wait_done();
        chk_word(sp0 - 32'h0000_0004, frame_base_reg);
        chk_word(sp0 - 32'h0000_0018, stack_ptr_reg);
    endtask

    // segment follows the operand base one cycle later
    task automatic run_seg();
        for (int k = 0; k < 4; k++) begin
            {opnd_base_frame, opnd_base_stack} = k[1:0];
            @(negedge ref_clk);
            chk_word({30'h0, (k == 0) ? sfel_pkg::SEG_DATA : sfel_pkg::SEG_STACK}, {30'h0, opnd_seg});
        end
        {opnd_base_frame, opnd_base_stack} = 2'h0;
    endtask

    task automatic chk_reset();
        chk_word(32'h0000_0000, frame_base_reg);
        chk_word(32'h0000_0000, stack_ptr_reg);
        chk_bit(1'b0, busy);
        chk_bit(1'b0, mem_req);
    endtask

    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        enter_req = 1'b0;
        leave_req = 1'b0;
        storage_bytes = '0;
        nest_level = '0;
        opnd_base_frame = 1'b0;
        opnd_base_stack = 1'b0;
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk_reset();
        run_seg();
        run_enter(32'h100, 0, 0);
        // back-to-back entry and release per level, storage and wait state
        for (int j = 0; j < 5; j++) begin
            run_enter(st[j], lv[j], wt[j]);
            run_leave();
        end
        run_freeze();
        // reset in mid-entry clears everything
        nest_level = 5'h3;
        enter_req = 1'b1;
        @(negedge ref_clk);
        enter_req = 1'b0;
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b1;
        @(negedge ref_clk);
        sys_rst = 1'b0;
        chk_reset();
        // the cut entry must not resume after release
        repeat (2) @(negedge ref_clk);
        chk_bit(1'b0, mem_req);
        chk_bit(1'b0, busy);
        conclude();
    end
endmodule
`default_nettype wire
